// *** pkg/fts_pkg.sv ***
`default_nettype none
// ****************************************************************
// Frame trigger sequencer shared definitions.
// ****************************************************************
package fts_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] FTS_OFF_CTRL     = 8'h00;
  localparam logic [7:0] FTS_OFF_FILTER   = 8'h04;
  localparam logic [7:0] FTS_OFF_INTERVAL = 8'h08;
  localparam logic [7:0] FTS_OFF_DELAY    = 8'h0C;
  localparam logic [7:0] FTS_OFF_COUNT    = 8'h10;
  localparam logic [7:0] FTS_OFF_SWTRIG   = 8'h14;
  localparam logic [7:0] FTS_OFF_STATUS   = 8'h18;
  localparam logic [7:0] FTS_OFF_OUTCTL   = 8'h1C;

  // Control register field positions.
  localparam int FTS_CTRL_MODE_LSB = 0;
  localparam int FTS_CTRL_OBST_BIT = 2;

  // Capture modes held in the control register.
  localparam logic [1:0] FTS_MODE_FREE = 2'd0;
  localparam logic [1:0] FTS_MODE_HW   = 2'd1;
  localparam logic [1:0] FTS_MODE_SW   = 2'd2;

  // Values after reset, in microseconds or frames.
  localparam logic [31:0] FTS_RST_FILTER   = 32'h0000_03E8;
  localparam logic [31:0] FTS_RST_INTERVAL = 32'h0001_1170;
  localparam logic [31:0] FTS_RST_DELAY    = 32'h0000_0000;
  localparam logic [7:0]  FTS_RST_COUNT    = 8'h01;

  // Legal ranges of the timing settings.
  localparam logic [31:0] FTS_INTERVAL_MIN = 32'h0001_1170;
  localparam logic [31:0] FTS_INTERVAL_MAX = 32'h0098_9680;
  localparam logic [31:0] FTS_DELAY_MAX    = 32'h05F5_E100;
  localparam logic [7:0]  FTS_COUNT_MIN    = 8'h01;
  localparam logic [7:0]  FTS_COUNT_MAX    = 8'hC8;

  // Timebase: one tick per microsecond from the 100 MHz clock.
  localparam int FTS_CLK_MHZ      = 100;
  localparam int FTS_TICK_US      = 1;
  localparam int FTS_TICK_CYCLES  = FTS_CLK_MHZ * FTS_TICK_US;

  // Sequencer states.
  typedef enum logic [2:0] {
    FTS_IDLE,
    FTS_FILTER,
    FTS_DELAY,
    FTS_FIRE,
    FTS_GAP
  } fts_state_t;

  // Frame start request and frame index pair.
  typedef struct packed {
    logic       start;
    logic [7:0] index;
  } fts_frame_req_t;

endpackage : fts_pkg
`default_nettype wire

// *** rtl/fts_tick.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Microsecond tick divider.
// ****************************************************************
module fts_tick #(
  parameter int DIV = fts_pkg::FTS_TICK_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  import fts_pkg::*;

  if (DIV < 2 || DIV > 65535) begin : g_div_chk
    $error("fts_tick: DIV out of range");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } fts_tick_st_t;

  fts_tick_st_t st_r;
  fts_tick_st_t st_nxt;

  // Count down and pulse for one cycle at the wrap.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == 16'h0000) begin
      st_nxt.cnt  = 16'(DIV - 1);
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : fts_tick
`default_nettype wire

// *** rtl/fts_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Three-stage pin synchroniser with agreement filter.
// ****************************************************************
module fts_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } fts_sync_st_t;

  fts_sync_st_t st_r;
  fts_sync_st_t st_nxt;

  // The first stage only feeds the second; level moves when 2 and 3 agree.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.level = st_r.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.level;

endmodule : fts_sync
`default_nettype wire

// *** rtl/fts_top.sv ***
// How it works
// - Trigger input pulses count only in hardware trigger mode.
// - Hardware mode idles and starts frames only after a valid input pulse.
// - After the burst the sequencer returns to idle, ready again once every issued frame is reported done.
// - After a trigger, wait the filter time then recheck the input level.
// - Frames in a burst are spaced by the interval, 70000 to 10000000 us.
// - After recheck wait the delay, 0 to 100000000 us; zero fires at once.
// - Each hardware trigger yields the programmed count of 1 to 200 frames.
// - Triggers arriving during a burst are discarded.
// - With a count of one the interval is never waited.
// - Software trigger mode and obstacle avoidance never both active.
// - Software mode starts only on a command, same filter, delay and burst.
// - Each software trigger yields the programmed count of 1 to 200 frames.
// - Both discrete inputs are active high; open reads as deasserted.
// - Discrete outputs only pull low or float, never drive high.
// - First frame after the delay, then one per interval up to count.
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module fts_top (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    trigger_input_primary,
  input  wire logic                    discrete_input_secondary,
  output logic                         discrete_output_first_oe,
  output logic                         discrete_output_first_o,
  output logic                         discrete_output_second_oe,
  output logic                         discrete_output_second_o,
  output fts_pkg::fts_frame_req_t      frame_req,
  input  wire logic                    frame_done
);
  import fts_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  mode;
    logic        obst;
    logic [31:0] filter;
    logic [31:0] interval;
    logic [31:0] delay;
    logic [7:0]  count;
    logic [1:0]  outctl;
    logic        sw_pend;
    logic        discards;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    fts_state_t  state;
    logic [31:0] timer;
    logic [7:0]  fired;
    logic [7:0]  done;
    logic        in_prev;
    logic        req;
    logic        burst_busy;
  } fts_top_st_t;

  fts_top_st_t st_r;
  fts_top_st_t st_nxt;
  logic        tick;
  logic        in1_lvl;
  logic        in2_lvl;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Merge write data into a word under byte strobes.
  function automatic logic [31:0] fts_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sb[i]) res[i*8 +: 8] = wd[i*8 +: 8];
    end
    return res;
  endfunction : fts_merge

  // Clamp a value into a closed range.
  function automatic logic [31:0] fts_clamp(input logic [31:0] v,
                                            input logic [31:0] lo,
                                            input logic [31:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : fts_clamp

  fts_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  fts_sync u_sync_in1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (trigger_input_primary),
    .level   (in1_lvl)
  );

  fts_sync u_sync_in2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (discrete_input_secondary),
    .level   (in2_lvl)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic        wr_go;
  logic        rd_go;
  logic        hw_edge;
  logic        trig;
  logic        trig_lvl;
  logic [31:0] wv;
  logic [31:0] st_word;

  always_comb begin
    st_nxt  = st_r;
    wr_go   = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    rd_go   = s_axi_arvalid && !st_r.rvalid;
    wv      = 32'h0000_0000;
    st_nxt.in_prev = in1_lvl;
    // Only a rising level on the input in hardware mode counts.
    hw_edge = (st_r.mode == FTS_MODE_HW) && in1_lvl &&
              !st_r.in_prev;
    trig    = hw_edge || st_r.sw_pend;
    // The recheck samples the primary input in hardware mode and always passes in software mode.
    trig_lvl = (st_r.mode == FTS_MODE_HW) ? in1_lvl : 1'b1;
    st_word = {16'h0000, st_r.fired, 3'b000, st_r.discards, in2_lvl,
               in1_lvl, st_r.burst_busy, st_r.state != FTS_IDLE};

    // Write address and data are taken in either order and held.
    if (s_axi_awvalid && !st_r.aw_got) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_got) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Register writes; values outside the legal range are clamped.
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = 2'b00;
      if (st_r.aw_addr == FTS_OFF_CTRL) begin
        wv = fts_merge({29'h0, st_r.obst, st_r.mode}, st_r.w_data,
                       st_r.w_strb);
        st_nxt.mode = wv[FTS_CTRL_MODE_LSB +: 2];
        st_nxt.obst = wv[FTS_CTRL_OBST_BIT];
        // Software mode wins; obstacle avoidance is forced off with it.
        if (st_nxt.mode == FTS_MODE_SW) st_nxt.obst = 1'b0;
        if (st_nxt.mode == 2'd3) st_nxt.mode = FTS_MODE_FREE;
      end else if (st_r.aw_addr == FTS_OFF_FILTER) begin
        st_nxt.filter = fts_merge(st_r.filter, st_r.w_data, st_r.w_strb);
      end else if (st_r.aw_addr == FTS_OFF_INTERVAL) begin
        wv = fts_merge(st_r.interval, st_r.w_data, st_r.w_strb);
        st_nxt.interval = fts_clamp(wv, FTS_INTERVAL_MIN,
                                    FTS_INTERVAL_MAX);
      end else if (st_r.aw_addr == FTS_OFF_DELAY) begin
        wv = fts_merge(st_r.delay, st_r.w_data, st_r.w_strb);
        st_nxt.delay = fts_clamp(wv, 32'h0, FTS_DELAY_MAX);
      end else if (st_r.aw_addr == FTS_OFF_COUNT) begin
        wv = fts_merge({24'h0, st_r.count}, st_r.w_data, st_r.w_strb);
        wv = fts_clamp(wv, {24'h0, FTS_COUNT_MIN}, {24'h0, FTS_COUNT_MAX});
        st_nxt.count = wv[7:0];
      end else if (st_r.aw_addr == FTS_OFF_SWTRIG) begin
        if (st_r.w_strb[0] && st_r.w_data[0] &&
            st_r.mode == FTS_MODE_SW) begin
          st_nxt.sw_pend = 1'b1;
        end
      end else if (st_r.aw_addr == FTS_OFF_OUTCTL) begin
        wv = fts_merge({30'h0, st_r.outctl}, st_r.w_data, st_r.w_strb);
        st_nxt.outctl = wv[1:0];
      end else if (st_r.aw_addr == FTS_OFF_STATUS) begin
        if (st_r.w_strb[0] && st_r.w_data[4]) st_nxt.discards = 1'b0;
      end else begin
        st_nxt.bresp = 2'b10;
      end
    end

    // Register reads answer one cycle after the address is taken.
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = 2'b00;
      if (s_axi_araddr == FTS_OFF_CTRL) begin
        st_nxt.rdata = {29'h0, st_r.obst, st_r.mode};
      end else if (s_axi_araddr == FTS_OFF_FILTER) begin
        st_nxt.rdata = st_r.filter;
      end else if (s_axi_araddr == FTS_OFF_INTERVAL) begin
        st_nxt.rdata = st_r.interval;
      end else if (s_axi_araddr == FTS_OFF_DELAY) begin
        st_nxt.rdata = st_r.delay;
      end else if (s_axi_araddr == FTS_OFF_COUNT) begin
        st_nxt.rdata = {24'h0, st_r.count};
      end else if (s_axi_araddr == FTS_OFF_SWTRIG) begin
        st_nxt.rdata = {31'h0, st_r.sw_pend};
      end else if (s_axi_araddr == FTS_OFF_STATUS) begin
        st_nxt.rdata = st_word;
      end else if (s_axi_araddr == FTS_OFF_OUTCTL) begin
        st_nxt.rdata = {30'h0, st_r.outctl};
      end else begin
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rresp = 2'b10;
      end
    end

    // Frame requests are single-cycle strobes.
    st_nxt.req = 1'b0;
    if (frame_done && st_r.done != st_r.fired) begin
      st_nxt.done = st_r.done + 8'h01;
    end
    // The burst stays busy until every issued frame is reported done.
    st_nxt.burst_busy = (st_r.state != FTS_IDLE) ||
                        (st_nxt.done != st_r.fired);

    // Timers advance on the microsecond tick only.
    if (tick && st_r.timer != 32'h0) begin
      st_nxt.timer = st_r.timer - 32'h0000_0001;
    end

    case (st_r.state)
      FTS_IDLE: begin
        if (trig && !st_r.burst_busy) begin
          st_nxt.sw_pend = 1'b0;
          st_nxt.timer   = st_r.filter;
          st_nxt.fired   = 8'h00;
          st_nxt.done    = 8'h00;
          st_nxt.state   = FTS_FILTER;
        end
      end
      FTS_FILTER: begin
        if (st_r.timer == 32'h0) begin
          // Recheck: noise that has gone away is dropped here.
          if (trig_lvl) begin
            st_nxt.timer = st_r.delay;
            st_nxt.state = FTS_DELAY;
          end else begin
            st_nxt.state = FTS_IDLE;
          end
        end
      end
      FTS_DELAY: begin
        if (st_r.timer == 32'h0) st_nxt.state = FTS_FIRE;
      end
      FTS_FIRE: begin
        st_nxt.req   = 1'b1;
        st_nxt.fired = st_r.fired + 8'h01;
        if (st_r.fired + 8'h01 >= st_r.count) begin
          st_nxt.state = FTS_IDLE;
        end else begin
          st_nxt.timer = st_r.interval;
          st_nxt.state = FTS_GAP;
        end
      end
      FTS_GAP: begin
        if (st_r.timer == 32'h0) st_nxt.state = FTS_FIRE;
      end
      default: st_nxt.state = FTS_IDLE;
    endcase

    // Triggers that land during a burst are dropped and noted.
    if (st_r.state != FTS_IDLE || st_r.burst_busy) begin
      if (hw_edge || st_r.sw_pend) begin
        st_nxt.discards = 1'b1;
        st_nxt.sw_pend  = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= '0;
      st_r.filter   <= FTS_RST_FILTER;
      st_r.interval <= FTS_RST_INTERVAL;
      st_r.delay    <= FTS_RST_DELAY;
      st_r.count    <= FTS_RST_COUNT;
      st_r.state    <= FTS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Bus handshakes; address and data are accepted while not yet held.
  assign s_axi_awready = !st_r.aw_got;
  assign s_axi_wready  = !st_r.w_got;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;

  // Open-drain outputs: the data line is always low; enable pulls down.
  assign discrete_output_first_o   = 1'b0;
  assign discrete_output_first_oe  = st_r.outctl[0];
  assign discrete_output_second_o  = 1'b0;
  assign discrete_output_second_oe = st_r.outctl[1];

  assign frame_req = {st_r.req, st_r.fired};

endmodule : fts_top
`default_nettype wire

// *** test/fts_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********************
// Port checker.
// ********************
module fts_assertions (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    discrete_output_first_o,
  input wire logic                    discrete_output_second_o,
  input wire fts_pkg::fts_frame_req_t frame_req
);
  import fts_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Outputs only sink or float; a high level would fight the pull-up.
  first_low_a: assert property (discrete_output_first_o == 1'b0)
    else $error("first output driven high");
  second_low_a: assert property (discrete_output_second_o == 1'b0)
    else $error("second output driven high");
  // Bus answers stand until taken and come within the stated cycles.
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  b_after_both_a: assert property ($rose(s_axi_bvalid)
    |-> $past(!s_axi_awready && !s_axi_wready))
    else $error("write answered before address and data");
  // Starts are far apart, so a start is never followed by another soon.
  start_space_a: assert property (frame_req.start
    |=> (!frame_req.start) [*8])
    else $error("frame starts too close");
  index_range_a: assert property (frame_req.start |=>
    frame_req.index >= 8'h01 && frame_req.index <= 8'hC8)
    else $error("frame number out of range");
endmodule : fts_assertions
bind fts_top fts_assertions i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .discrete_output_first_o(discrete_output_first_o),
  .discrete_output_second_o(discrete_output_second_o),
  .frame_req(frame_req)
);
`default_nettype wire

// *** test/fts_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********************
// Trigger source and capture pipeline model.
// ********************
module fts_partner (
  input  wire logic                    aclk,
  input  wire fts_pkg::fts_frame_req_t frame_req,
  output logic                         trig,
  output logic                         sec,
  output logic                         done
);
  import fts_pkg::*;
  int lat = 5, cnt = 0;
  // Released inputs read as deasserted, so they rest low.
  initial begin
    trig = 1'b0;
    sec = 1'b0;
    done = 1'b0;
  end
  // A slow pipeline keeps the sequencer busy longer; lat sets it.
  always @(posedge aclk) begin
    done <= (frame_req.start !== 1'b1) && (cnt == 1);
    if (frame_req.start === 1'b1) begin
      cnt <= lat;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Active-high trigger pulse of len cycles.
  task automatic pulse(input int len);
    trig <= 1'b1;
    repeat (len) @(posedge aclk);
    trig <= 1'b0;
  endtask : pulse
  task automatic set_sec(input logic v);
    sec <= v;
  endtask : set_sec
endmodule : fts_partner
`default_nettype wire

// *** test/fts_top_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module fts_top_tb_top;
  import fts_pkg::*;
  // ********************
  // Signals and instances.
  // ********************
  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  logic [7:0]     awaddr = 8'h00;
  logic [7:0]     araddr = 8'h00;
  logic [31:0]    wdata = 32'h0000_0000;
  logic [3:0]     wstrb = 4'hF;
  logic           awvalid = 1'b0;
  logic           wvalid = 1'b0;
  logic           bready = 1'b0;
  logic           arvalid = 1'b0;
  logic           rready = 1'b0;
  logic           awready, wready, bvalid, arready, rvalid;
  logic [1:0]     bresp, rresp, resp;
  logic [31:0]    rdata, rd;
  logic           oe1, o1, oe2, o2, trig, sec, done;
  fts_frame_req_t frame_req;
  int             error_cnt = 0;
  int             n_compared = 0;
  int             cyc = 0;
  int             n_start = 0;
  int             t_start = 0;
  fts_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trigger_input_primary(trig),
    .discrete_input_secondary(sec), .discrete_output_first_oe(oe1),
    .discrete_output_first_o(o1), .discrete_output_second_oe(oe2),
    .discrete_output_second_o(o2), .frame_req(frame_req),
    .frame_done(done)
  );
  fts_partner i_partner (
    .aclk(aclk), .frame_req(frame_req), .trig(trig), .sec(sec),
    .done(done)
  );
  always #5 aclk = ~aclk;
  // Count frame starts; the ceiling is far above the run's length.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (frame_req.start === 1'b1) begin
      n_start <= n_start + 1;
      t_start <= cyc;
    end
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ********************
  // Shared tasks.
  // ********************
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic in_win(input int d, input int lo, input int hi);
    return d >= lo && d <= hi;
  endfunction : in_win
  // Ready is raised late on purpose so the answer must wait for it.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // Short filter keeps runs brief; the interval stays legal.
  task automatic setup(input logic [1:0] m, input logic [31:0] dly);
    axi_wr(FTS_OFF_FILTER, 32'h0000_0002);
    axi_wr(FTS_OFF_DELAY, dly);
    axi_wr(FTS_OFF_COUNT, 32'h0000_0001);
    axi_wr(FTS_OFF_CTRL, {30'h0, m});
  endtask : setup
  task automatic wait_start(input int s0);
    int n;
    n = 0;
    while (n_start == s0 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_start
  // ********************
  // Scenarios.
  // ********************
  task automatic t_regs();
    logic [7:0]  a [6] = '{FTS_OFF_CTRL, FTS_OFF_FILTER, FTS_OFF_INTERVAL,
      FTS_OFF_DELAY, FTS_OFF_COUNT, 8'h20};
    logic [31:0] e [6] = '{32'h0, FTS_RST_FILTER, FTS_RST_INTERVAL,
      FTS_RST_DELAY, {24'h0, FTS_RST_COUNT}, 32'h0};
    for (int i = 0; i < 6; i++) begin
      axi_rd(a[i]);
      chk(rd, e[i]);
      chk({30'h0, resp}, (i == 5) ? 32'h2 : 32'h0);
    end
    axi_wr(8'h20, 32'h0000_0001);
    chk({30'h0, resp}, 32'h0000_0002);
  endtask : t_regs
  // Out-of-range settings are clamped; obstacle mode yields to SW mode.
  task automatic t_clamp();
    logic [7:0]  a [6] = '{FTS_OFF_INTERVAL, FTS_OFF_INTERVAL,
      FTS_OFF_DELAY, FTS_OFF_COUNT, FTS_OFF_COUNT, FTS_OFF_CTRL};
    logic [31:0] w [6] = '{32'h5, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0,
      32'hFA, 32'h6};
    logic [31:0] e [6] = '{FTS_INTERVAL_MIN, FTS_INTERVAL_MAX,
      FTS_DELAY_MAX, {24'h0, FTS_COUNT_MIN}, {24'h0, FTS_COUNT_MAX}, 32'h2};
    for (int i = 0; i < 6; i++) begin
      axi_wr(a[i], w[i]);
      axi_rd(a[i]);
      chk(rd, e[i]);
    end
  endtask : t_clamp
  task automatic t_hw();
    int s0;
    int c0;
    setup(FTS_MODE_HW, 32'h0000_0003);
    i_partner.lat = 150;
    s0 = n_start;
    c0 = cyc;
    i_partner.pulse(300);
    repeat (50) @(posedge aclk);
    i_partner.pulse(20);
    wait_start(s0);
    chk({31'h0, in_win(t_start - c0, 390, 620)}, 32'h1);
    axi_rd(FTS_OFF_STATUS);
    chk(rd & 32'h0000_0012, 32'h0000_0012);
    repeat (500) @(posedge aclk);
    axi_rd(FTS_OFF_STATUS);
    chk(rd & 32'h0000_0002, 32'h0);
    chk(32'(n_start - s0), 32'h1);
    axi_wr(FTS_OFF_STATUS, 32'h0000_0010);
    i_partner.lat = 5;
    i_partner.pulse(300);
    wait_start(s0 + 1);
    chk(32'(n_start - s0), 32'h2);
    repeat (300) @(posedge aclk);
  endtask : t_hw
  // Pin ignored outside HW mode, glitch rejected, command ignored in HW.
  task automatic t_gate();
    int s0;
    setup(FTS_MODE_SW, 32'h0);
    s0 = n_start;
    i_partner.pulse(300);
    setup(FTS_MODE_HW, 32'h0);
    i_partner.pulse(20);
    axi_wr(FTS_OFF_SWTRIG, 32'h0000_0001);
    repeat (800) @(posedge aclk);
    chk(32'(n_start - s0), 32'h0);
  endtask : t_gate
  task automatic t_sw();
    int s0;
    int c0;
    setup(FTS_MODE_SW, 32'h0);
    s0 = n_start;
    c0 = cyc;
    axi_wr(FTS_OFF_SWTRIG, 32'h0000_0001);
    wait_start(s0);
    chk({31'h0, in_win(t_start - c0, 100, 330)}, 32'h1);
    repeat (400) @(posedge aclk);
    chk(32'(n_start - s0), 32'h1);
  endtask : t_sw
  task automatic t_pins();
    axi_wr(FTS_OFF_OUTCTL, 32'h0000_0003);
    chk({28'h0, oe1, o1, oe2, o2}, 32'h0000_000A);
    i_partner.set_sec(1'b1);
    repeat (4) @(posedge aclk);
    axi_rd(FTS_OFF_STATUS);
    chk(rd & 32'h0000_0008, 32'h0000_0008);
    i_partner.set_sec(1'b0);
    repeat (4) @(posedge aclk);
    axi_rd(FTS_OFF_STATUS);
    chk(rd & 32'h0000_0008, 32'h0);
    wstrb <= 4'h2;
    axi_wr(FTS_OFF_FILTER, 32'h1234_5605);
    axi_rd(FTS_OFF_FILTER);
    chk(rd, 32'h0000_5602);
  endtask : t_pins
  // Main sequence after a reset of twelve cycles.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_clamp();
    t_hw();
    t_gate();
    t_sw();
    t_pins();
    print_verdict();
  end
endmodule : fts_top_tb_top
`default_nettype wire
